// ===== rtl/step_scan_pkg.sv
/*
 * Package for the step logic scan engine and output router: register
 * offsets, reset values, setting ranges and pass timing.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
package step_scan_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_STEPS = 10;
	localparam int NUM_ROUTED = 5;
	localparam int NUM_TERMINALS = 5;
	localparam int NUM_EXT_IN = 16;
	localparam int SET_W = 16;
	localparam int ADDR_W = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned PASS_MS = 2;
	localparam int unsigned TERM_REFRESH_MS = 5;
	localparam int unsigned PASS_CYCLES = CLK_HZ / 1000 * PASS_MS;
	localparam int unsigned TERM_REFRESH_CYCLES = CLK_HZ / 1000 * TERM_REFRESH_MS;
	localparam int TICK_W = 17;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] STEP_SELECT_BASE = 4'h0;
	localparam logic [ADDR_W-1:0] FUNCTION_BASE = 4'h5;
	localparam logic [ADDR_W-1:0] MONITOR_SELECT_ADDR = 4'ha;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hb;
	localparam logic [ADDR_W-1:0] MONITOR_VALUE_ADDR = 4'hc;

	// ------------------------------------------------------------
	// Reset values and ranges
	// ------------------------------------------------------------
	localparam logic [SET_W-1:0] STEP_SELECT_RESET = 16'h0000;
	localparam logic [SET_W-1:0] FUNCTION_RESET = 16'h0064;
	localparam logic [SET_W-1:0] MONITOR_SELECT_RESET = 16'h0001;
	localparam logic [SET_W-1:0] STEP_SELECT_MAX = 16'h000a;
	localparam logic [SET_W-1:0] FUNC_LOW_MAX = 16'h0064;
	localparam logic [SET_W-1:0] FUNC_HIGH_MIN = 16'h03e8;
	localparam logic [SET_W-1:0] FUNC_HIGH_MAX = 16'h0439;
	localparam logic [SET_W-1:0] FUNC_CANCEL = 16'h0050;
	localparam logic [SET_W-1:0] FUNC_CANCEL_INV = 16'h0438;
	localparam logic [SET_W-1:0] FUNC_CLEAR = 16'h0051;
	localparam logic [SET_W-1:0] FUNC_CLEAR_INV = 16'h0439;

	// ------------------------------------------------------------
	// Scan phases
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_EVAL,
		PH_UPDATE
	} phase_e;

endpackage

// ===== rtl/period_tick.sv
/*
 * Free-running divider that pulses once every PERIOD clock cycles.
 * Assumes PERIOD is at least one and fits in the counter width.
 */
`timescale 1ns/10ps
`default_nettype none

module period_tick
	import step_scan_pkg::*;
#(
	parameter int unsigned PERIOD = PASS_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_rst,
	output logic o_tick
);

	typedef struct packed {
		logic [TICK_W-1:0] count;
		logic tick;
	} tick_s;

	tick_s state;
	tick_s next_state;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (state.count == TICK_W'(PERIOD - 1))
		begin
			next_state.count = '0;
			next_state.tick = 1'b1;
		end
		else
		begin
			next_state.count = state.count + TICK_W'(1);
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign o_tick = state.tick;

endmodule // period_tick

`default_nettype wire

// ===== rtl/step_scan_router.sv
/*
 * Scan engine and output router for a ten-step programmable logic unit.
 * The per-step functions sit outside: in each of the ten eval cycles of a pass the engine
 * names one step, and the step logic answers combinationally with that
 * step's result, reading the latched inputs and the step result vector.
 * Timer and counter values of all steps arrive as one flat input bus.
 */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module step_scan_router
	import step_scan_pkg::*;
#(
	parameter int unsigned PASS_PERIOD = PASS_CYCLES,
	parameter int unsigned TERM_PERIOD = TERM_REFRESH_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [SET_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [SET_W-1:0] o_rdata,
	input wire logic [NUM_EXT_IN-1:0] i_ext_inputs,
	output logic [NUM_EXT_IN-1:0] o_latched_inputs,
	output logic o_eval_strobe,
	output logic [3:0] o_eval_step,
	input wire logic i_eval_result,
	output logic [NUM_STEPS-1:0] o_step_result,
	input wire logic [NUM_STEPS*SET_W-1:0] i_step_timer_values,
	output logic [SET_W-1:0] o_monitor_value,
	output logic [NUM_ROUTED-1:0] o_routed_output,
	output logic [NUM_ROUTED-1:0] o_routed_drive,
	output logic [NUM_ROUTED*SET_W-1:0] o_routed_function,
	input wire logic [NUM_TERMINALS*3-1:0] i_terminal_output_function_setting,
	output logic [NUM_TERMINALS-1:0] o_terminal,
	input wire logic i_cancel_logic_command,
	input wire logic i_clear_logic_timers_command,
	output logic o_logic_bypass,
	output logic o_clear_timers,
	output logic o_pass_done
);

	typedef struct packed {
		phase_e phase;
		logic [3:0] step;
		logic [NUM_EXT_IN-1:0] latched;
		logic [NUM_STEPS-1:0] result;
		logic [NUM_ROUTED-1:0] routed;
		logic [NUM_ROUTED-1:0][SET_W-1:0] sel;
		logic [NUM_ROUTED-1:0][SET_W-1:0] func;
		logic [SET_W-1:0] mon_sel;
		logic [SET_W-1:0] mon_value;
		logic [SET_W-1:0] rdata;
		logic [NUM_TERMINALS-1:0] terminal;
		logic first_pass_done;
		logic pass_done;
	} scan_s;

	scan_s state;
	scan_s next_state;

	logic pass_tick;
	logic term_tick;
	logic [NUM_ROUTED-1:0] routed_value;
	logic [NUM_ROUTED-1:0] routed_drive;
	logic [NUM_ROUTED-1:0] is_cancel;
	logic [NUM_ROUTED-1:0] is_clear;
	logic [NUM_TERMINALS-1:0] terminal_value;
	logic [SET_W-1:0] selected_value;

	// ------------------------------------------------------------
	// Pass and terminal refresh timing
	// ------------------------------------------------------------
	period_tick #(
		.PERIOD(PASS_PERIOD)
	) u_pass_tick (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.o_tick(pass_tick)
	);

	period_tick #(
		.PERIOD(TERM_PERIOD)
	) u_term_tick (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.o_tick(term_tick)
	);

	// ------------------------------------------------------------
	// Per-output routing and per-terminal selection
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_ROUTED; g++)
		begin : g_routed
			// Disabled outputs read zero so they drive an inactive level, unless the function code is inverted
			assign routed_value[g] = (state.sel[g] == '0) ? 1'b0 :
				state.result[state.sel[g][3:0] - 4'h1];
			// Inverted function codes deliver the opposite sense
			assign routed_drive[g] = (state.func[g] >= FUNC_HIGH_MIN) ?
				~state.routed[g] : state.routed[g];
			assign is_cancel[g] = (state.func[g] == FUNC_CANCEL) ||
				(state.func[g] == FUNC_CANCEL_INV);
			assign is_clear[g] = (state.func[g] == FUNC_CLEAR) ||
				(state.func[g] == FUNC_CLEAR_INV);
		end
		for (g = 0; g < NUM_TERMINALS; g++)
		begin : g_term
			logic [2:0] tsel;
			assign tsel = i_terminal_output_function_setting[g*3 +: 3];
			assign terminal_value[g] = (tsel >= 3'h1 && tsel <= 3'h5) ?
				state.routed[tsel - 3'h1] : 1'b0;
		end
	endgenerate

	// Monitor value of the selected step, index already range-checked
	assign selected_value = i_step_timer_values[(state.mon_sel[3:0] - 4'h1)*SET_W +: SET_W];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.pass_done = 1'b0;
		next_state.rdata = '0;

		// Scan sequence
		case (state.phase)
			PH_IDLE:
			begin
				if (pass_tick)
				begin
					next_state.latched = i_ext_inputs;
					next_state.step = 4'h1;
					next_state.phase = PH_EVAL;
				end
			end
			PH_EVAL:
			begin
				// Stored at once, so the next step already sees it
				next_state.result[state.step - 4'h1] = i_eval_result;
				if (state.step == NUM_STEPS[3:0])
					next_state.phase = PH_UPDATE;
				else
					next_state.step = state.step + 4'h1;
			end
			PH_UPDATE:
			begin
				next_state.routed = routed_value;
				next_state.first_pass_done = 1'b1;
				next_state.pass_done = 1'b1;
				next_state.phase = PH_IDLE;
			end
			default:
			begin
				next_state.phase = PH_IDLE;
			end
		endcase

		// Terminals sample the routed outputs only on the slow refresh,
		// so pulses shorter than the refresh can be missed
		if (term_tick)
			next_state.terminal = terminal_value;

		// Monitor value follows the selected step every cycle
		next_state.mon_value = selected_value;

		// Register writes; out-of-range values are dropped
		if (i_wr)
		begin
			if (i_addr < FUNCTION_BASE)
			begin
				if (i_wdata <= STEP_SELECT_MAX)
					next_state.sel[i_addr - STEP_SELECT_BASE] = i_wdata;
			end
			else if (i_addr < MONITOR_SELECT_ADDR)
			begin
				if (i_wdata <= FUNC_LOW_MAX ||
					(i_wdata >= FUNC_HIGH_MIN && i_wdata <= FUNC_HIGH_MAX))
					next_state.func[i_addr - FUNCTION_BASE] = i_wdata;
			end
			else if (i_addr == MONITOR_SELECT_ADDR)
			begin
				if (i_wdata >= 16'h0001 && i_wdata <= STEP_SELECT_MAX)
					next_state.mon_sel = i_wdata;
			end
		end

		// Register reads, answered in the following cycle
		if (i_rd)
		begin
			if (i_addr < FUNCTION_BASE)
				next_state.rdata = state.sel[i_addr - STEP_SELECT_BASE];
			else if (i_addr < MONITOR_SELECT_ADDR)
				next_state.rdata = state.func[i_addr - FUNCTION_BASE];
			else if (i_addr == MONITOR_SELECT_ADDR)
				next_state.rdata = state.mon_sel;
			else if (i_addr == STATUS_ADDR)
				// Sixteen bits hold bypass, routed and results; clear has no room
				next_state.rdata = {o_logic_bypass, state.routed, state.result};
			else if (i_addr == MONITOR_VALUE_ADDR)
				next_state.rdata = state.mon_value;
			else
				next_state.rdata = '0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state <= '0;
			state.phase <= PH_IDLE;
			state.sel <= {NUM_ROUTED{STEP_SELECT_RESET}};
			state.func <= {NUM_ROUTED{FUNCTION_RESET}};
			state.mon_sel <= MONITOR_SELECT_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rdata = state.rdata;
	assign o_latched_inputs = state.latched;
	assign o_eval_strobe = (state.phase == PH_EVAL);
	assign o_eval_step = (state.phase == PH_EVAL) ? state.step : 4'h0;
	assign o_step_result = state.result;
	assign o_monitor_value = state.mon_value;
	assign o_routed_output = state.routed;
	// Inverted codes stay inactive too until the first pass has run
	assign o_routed_drive = state.first_pass_done ? routed_drive : '0;
	assign o_routed_function = state.func;
	assign o_terminal = state.terminal;
	assign o_logic_bypass = i_cancel_logic_command ||
		(|(is_cancel & o_routed_drive));
	assign o_clear_timers = i_clear_logic_timers_command ||
		(|(is_clear & o_routed_drive));
	assign o_pass_done = state.pass_done;

endmodule // step_scan_router

`default_nettype wire

// ===== tb/step_logic_model.sv
/*
 * Model of the per-step logic that faces the scan engine.
 * Assumes the engine samples the answer in the cycle it names a step.
 */
`timescale 1ns/10ps
`default_nettype none

module step_logic_model
	import step_scan_pkg::*;
(
	input wire logic [3:0] i_eval_step,
	input wire logic [NUM_EXT_IN-1:0] i_latched_inputs,
	input wire logic [NUM_STEPS-1:0] i_step_result,
	output logic o_eval_result,
	output logic [NUM_STEPS*SET_W-1:0] o_step_timer_values
);
	// Each step after the first chains the one before it, so a stale earlier result shows at once
	always_comb
	begin
		o_eval_result = 1'b0;
		if (i_eval_step == 4'h1)
			o_eval_result = i_latched_inputs[0];
		else if (i_eval_step != 4'h0 && i_eval_step <= 4'ha)
			o_eval_result = i_latched_inputs[i_eval_step - 4'h1] ^ i_step_result[i_eval_step - 4'h2];
		for (int k = 0; k < NUM_STEPS; k++)
			o_step_timer_values[k*SET_W +: SET_W] = 16'h0100 + SET_W'(k + 1);
	end
endmodule // step_logic_model

`default_nettype wire

// ===== tb/step_scan_router_checker.sv
/*
 * Checker for the scan router: step order, pass timing, output update.
 * Assumes it is bound to step_scan_router and sees its ports only.
 */
`timescale 1ns/10ps
`default_nettype none

module step_scan_router_checker
	import step_scan_pkg::*;
#(
	parameter int unsigned PASS_PERIOD = PASS_CYCLES,
	parameter int unsigned TERM_PERIOD = TERM_REFRESH_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [NUM_EXT_IN-1:0] o_latched_inputs,
	input wire logic o_eval_strobe,
	input wire logic [3:0] o_eval_step,
	input wire logic [NUM_ROUTED-1:0] o_routed_output,
	input wire logic [NUM_TERMINALS-1:0] o_terminal,
	input wire logic i_cancel_logic_command,
	input wire logic i_clear_logic_timers_command,
	input wire logic o_logic_bypass,
	input wire logic o_clear_timers,
	input wire logic o_pass_done
);
	// Gaps are counted, not delayed: real periods run to tens of thousands of cycles
	int unsigned pass_gap;
	int unsigned term_gap;
	logic seen_done;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			pass_gap <= 0;
			term_gap <= 0;
			seen_done <= 1'b0;
		end
		else
		begin
			pass_gap <= o_pass_done ? 0 : pass_gap + 1;
			term_gap <= $changed(o_terminal) ? 0 : term_gap + 1;
			seen_done <= seen_done | o_pass_done;
		end
	end
	eval_span_a:
	assert property ($rose(o_eval_strobe) |-> (o_eval_step == 4'h1) ##9 (o_eval_step == 4'ha)
		##1 !o_eval_strobe) else $error("eval window wrong");
	step_order_a:
	assert property (o_eval_strobe && o_eval_step != 4'ha |=> o_eval_step == $past(o_eval_step) + 4'h1)
		else $error("step order wrong");
	update_time_a:
	assert property ($fell(o_eval_strobe) |=> o_pass_done) else $error("update not after eval");
	routed_hold_a:
	assert property (!o_pass_done |-> $stable(o_routed_output)) else $error("routed changed mid pass");
	pass_period_a:
	assert property (o_pass_done && seen_done |-> pass_gap == PASS_PERIOD - 1) else $error("pass period");
	latch_once_a:
	assert property (!$rose(o_eval_strobe) |-> $stable(o_latched_inputs)) else $error("late latch");
	cancel_bypass_a:
	assert property (i_cancel_logic_command |-> o_logic_bypass) else $error("cancel not bypassing");
	clear_hold_a:
	assert property (i_clear_logic_timers_command |-> o_clear_timers) else $error("clear not held");
	term_refresh_a:
	assert property ($changed(o_terminal) |-> term_gap >= TERM_PERIOD - 1) else $error("terminal early");
	cover property ($rose(o_eval_strobe));
	cover property (o_logic_bypass && !i_cancel_logic_command);
	cover property ($changed(o_terminal));
endmodule // step_scan_router_checker

bind step_scan_router step_scan_router_checker #(.PASS_PERIOD(PASS_PERIOD), .TERM_PERIOD(TERM_PERIOD))
	u_checker (.i_mclk, .i_rst, .o_latched_inputs, .o_eval_strobe, .o_eval_step, .o_routed_output,
	.o_terminal, .i_cancel_logic_command, .i_clear_logic_timers_command, .o_logic_bypass,
	.o_clear_timers, .o_pass_done);

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Testbench for the scan router: register access, routing, timing, commands.
 * Assumes the step logic model on the far side and short pass periods.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import step_scan_pkg::*;
	logic i_mclk, i_rst, i_wr, i_rd, i_eval_result, o_eval_strobe, o_pass_done, o_logic_bypass;
	logic i_cancel_logic_command, i_clear_logic_timers_command, o_clear_timers;
	logic [3:0] i_addr, o_eval_step;
	logic [15:0] i_wdata, o_rdata, i_ext_inputs, o_latched_inputs, o_monitor_value;
	logic [9:0] o_step_result;
	logic [159:0] i_step_timer_values;
	logic [4:0] o_routed_output, o_routed_drive, o_terminal, ro;
	logic [79:0] o_routed_function;
	logic [14:0] i_terminal_output_function_setting;
	logic [15:0] sel [5] = '{16'h0000, 16'h0001, 16'h0005, 16'h000a, 16'h0003};
	logic [15:0] fn [5] = '{16'h0000, 16'h03e8, 16'h0064, 16'h0001, 16'h03ff};
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;

	step_scan_router #(.PASS_PERIOD(40), .TERM_PERIOD(100)) u_step_scan_router (.i_mclk, .i_rst,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_inputs, .o_latched_inputs, .o_eval_strobe,
		.o_eval_step, .i_eval_result, .o_step_result, .i_step_timer_values, .o_monitor_value,
		.o_routed_output, .o_routed_drive, .o_routed_function, .i_terminal_output_function_setting,
		.o_terminal, .i_cancel_logic_command, .i_clear_logic_timers_command, .o_logic_bypass,
		.o_clear_timers, .o_pass_done);
	step_logic_model u_step_logic_model (.i_eval_step(o_eval_step), .i_latched_inputs(o_latched_inputs),
		.i_step_result(o_step_result), .o_eval_result(i_eval_result),
		.o_step_timer_values(i_step_timer_values));

	initial
	begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Far longer than the whole sequence, which ends within a few thousand cycles
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			give_verdict;
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 check("rdata", e, o_rdata);
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		@(posedge i_mclk);
		#1;
		while (o_pass_done !== 1'b1 && n < 100)
		begin
			@(posedge i_mclk);
			#1 n++;
		end
		check("pass_done", 1, o_pass_done);
	endtask

	function automatic logic [9:0] exp_res(input logic [15:0] x);
		logic a;
		a = 1'b0;
		for (int k = 0; k < 10; k++)
		begin
			a = a ^ x[k];
			exp_res[k] = a;
		end
	endfunction

	task automatic check_route(input logic [15:0] x);
		logic [9:0] r;
		r = exp_res(x);
		for (int g = 0; g < 5; g++)
			ro[g] = (sel[g] == 16'h0000) ? 1'b0 : r[sel[g] - 16'h0001];
		check("step_result", r, o_step_result);
		check("routed", ro, o_routed_output);
		check("drive", ro ^ {fn[4] >= 16'h03e8, fn[3] >= 16'h03e8, fn[2] >= 16'h03e8,
			fn[1] >= 16'h03e8, fn[0] >= 16'h03e8}, o_routed_drive);
	endtask

	initial
	begin
		int n;
		logic [4:0] te;
		logic [2:0] s;
		{i_rst, i_wr, i_rd, i_cancel_logic_command, i_clear_logic_timers_command} = 5'h10;
		{i_addr, i_wdata, i_ext_inputs} = 36'h0;
		i_terminal_output_function_setting = {3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		#1 check("drive_reset", 0, o_routed_drive);
		for (int g = 0; g < 5; g++)
		begin
			rd(4'(g), 16'h0000);
			rd(4'(g + 5), 16'h0064);
		end
		rd(4'ha, 16'h0001);
		rd(4'hd, 16'h0000);
		wr(4'h0, 16'h000b);
		wr(4'h5, 16'h0065);
		wr(4'h6, 16'h03e7);
		wr(4'h7, 16'h043a);
		wr(4'ha, 16'h000b);
		rd(4'h0, 16'h0000);
		rd(4'h5, 16'h0064);
		rd(4'h6, 16'h0064);
		rd(4'h7, 16'h0064);
		rd(4'ha, 16'h0001);
		for (int g = 0; g < 5; g++)
		begin
			wr(4'(g), sel[g]);
			wr(4'(g + 5), fn[g]);
			rd(4'(g + 5), fn[g]);
			check("routed_function", fn[g], o_routed_function[g*16 +: 16]);
		end
		for (int k = 1; k <= 10; k++)
		begin
			wr(4'ha, 16'(k));
			rd(4'hc, 16'h0100 + 16'(k));
			check("monitor_value", 16'h0100 + 16'(k), o_monitor_value);
		end
		i_ext_inputs <= 16'h0235;
		wait_done;
		wait_done;
		check_route(16'h0235);
		n = 0;
		while (o_eval_step !== 4'h5 && n < 100)
		begin
			@(posedge i_mclk);
			#1 n++;
		end
		@(posedge i_mclk);
		i_ext_inputs <= 16'h0f0f;
		wait_done;
		check_route(16'h0235);
		check("latched", 16'h0235, o_latched_inputs);
		wait_done;
		check_route(16'h0f0f);
		i_ext_inputs <= 16'h0235;
		wait_done;
		check_route(16'h0235);
		// Routed levels stay put just past two 100-cycle refreshes, so the terminals have sampled them
		repeat (205) @(posedge i_mclk);
		#1;
		for (int j = 0; j < 5; j++)
		begin
			s = i_terminal_output_function_setting[j*3 +: 3];
			te[j] = (s >= 3'h1 && s <= 3'h5) ? ro[s - 3'h1] : 1'b0;
		end
		check("terminal", te, o_terminal);
		foreach (fn[i])
			fn[i] = (i == 2) ? 16'h0050 : (i == 3) ? 16'h0051 : fn[i];
		wr(4'h7, 16'h0050);
		wr(4'h8, 16'h0051);
		wait_done;
		check("bypass", 1, o_logic_bypass);
		check("clear", 1, o_clear_timers);
		wr(4'h7, 16'h0438);
		wr(4'h8, 16'h0439);
		wait_done;
		check("bypass_inv", 0, o_logic_bypass);
		check("clear_inv", 0, o_clear_timers);
		i_cancel_logic_command <= 1'b1;
		i_clear_logic_timers_command <= 1'b1;
		wait_done;
		check("bypass_cmd", 1, o_logic_bypass);
		check("clear_cmd", 1, o_clear_timers);
		rd(4'hb, {1'b1, ro, exp_res(16'h0235)});
		give_verdict;
	end
endmodule // testbench

`default_nettype wire
